// >>> shared/uart_tx_pkg.sv
// Constants, register map and carriers for the serial transmitter.
// Assumes a single 20 MHz system clock and a plain register port.
// Notes on behaviour
// - Line rests high (mark); one is mark, zero is space.
// - Frame is one low start bit, eight or nine data bits, stop.
// - Every bit but a start bit sent from idle holds the line for exactly one baud period.
// - Data bits leave least significant first.
// - Transmit runs independently, sharing format and rate settings.
// - No hardware parity; software may use the ninth bit.
// - Bit timing from an 8-bit or 16-bit down-counting rate divider.
// - Port enable together with transmit enable makes the serial output pin a driven output.
// - Clearing transmit enable or port enable releases the pin to general purpose use; sync alone keeps it driven.
// - Holding write starts sending; idle shifter loads at once.
// - Busy shifter: character waits until the stop bit ends, then moves.
// - Start bit begins right after the transfer to the shifter.
// - Ready flag set when enabled and holding register empty.
// - Setting transmit enable, with port enable set and sync clear, sets the ready flag.
// - Ready flag becomes valid in third cycle after a write.
// - Ready flag is read only; writes do not touch it.
// - Interrupt request gated by enable; flag tracks emptiness regardless.
// - Shift register is hidden; loaded only from holding register.
// - Shifter empty status: set when empty, clear from load to end.
// - Nine-bit mode sends ninth data bit as most significant.
package uart_tx_pkg;

   // ***********************************
   // Register offsets
   // ***********************************
   localparam logic [3:0] CTRL_ADDR    = 4'h0;
   localparam logic [3:0] DATA_ADDR    = 4'h1;
   localparam logic [3:0] STATUS_ADDR  = 4'h2;
   localparam logic [3:0] DIV_ADDR     = 4'h3;

   // ***********************************
   // Control field positions
   // ***********************************
   localparam int CTRL_TX_EN    = 0;
   localparam int CTRL_PORT_EN  = 1;
   localparam int CTRL_SYNC     = 2;
   localparam int CTRL_NINE     = 3;
   localparam int CTRL_NINTH_D  = 4;
   localparam int CTRL_IRQ_EN   = 5;
   localparam int CTRL_DIV16    = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   // Status field positions
   localparam int STAT_READY    = 0;
   localparam int STAT_EMPTY    = 1;

   // Divider reset value
   localparam logic [15:0] DIV_RESET = 16'h0000;

   // Timing: ready flag lag after a write, in cycles
   localparam int READY_LAG = 2;

   // ***********************************
   // Carriers
   // ***********************************
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_s;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_e;

endpackage : uart_tx_pkg

// >>> testbench/serial_rx_model.sv
// Remote serial receiver model watching the transmit line.
// Assumes the line is sampled on clk_i; bit period given in cycles.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model (
   // Clock and setup
   input  wire logic        clk_i,
   input  wire logic        en_i,
   input  wire logic        nine_i,
   input  wire logic [15:0] period_i,
   // Line and result
   input  wire logic        line_i,
   output logic             valid_o = 1'b0,
   output logic [9:0]       char_o = 10'h000
);
   // ****
   // Receive engine
   // ****
   logic       prev_r = 1'b1;
   int         cnt_r = 0;
   int         idx_r = -1;
   logic [8:0] sh_r = 9'h000;

   // idle mark, start edge, bit grid
   always @(posedge clk_i) begin
      valid_o <= 1'b0;
      prev_r <= line_i;
      if (!en_i) begin
         idx_r <= -1;
      end else if (idx_r < 0) begin
         if (prev_r === 1'b1 && line_i === 1'b0) begin
            idx_r <= 0;
            cnt_r <= 1;
         end
      end else if (cnt_r < int'(period_i)) begin
         cnt_r <= cnt_r + 1;
      end else begin
         cnt_r <= 1;
         if (idx_r == (nine_i ? 9 : 8)) begin
            // Stop bit low is reported in the top bit
            valid_o <= 1'b1;
            char_o <= {~line_i, nine_i ? sh_r : {1'b0, sh_r[7:0]}};
            idx_r <= -1;
         end else begin
            sh_r[idx_r] <= line_i;
            idx_r <= idx_r + 1;
         end
      end
   end
endmodule : serial_rx_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the serial transmitter.
// Assumes the receiver model beside it and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ****
   // Signals and instances
   // ****
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic        line, oe, irq, async;
   logic        rx_en = 1'b0;
   logic        nine = 1'b0;
   logic [15:0] period = 16'h0004;
   logic        rx_v;
   logic [9:0]  rx_c;
   logic        rd_d = 1'b0;
   logic [31:0] seed = 32'h2535731f;
   logic [15:0] rd_q[$];
   logic [9:0]  rx_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;

   // Clock of 50 ns
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   uart_tx dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .serial_out_o(line), .serial_out_oe_o(oe),
      .transmit_irq_o(irq), .async_mode_o(async));
   serial_rx_model rx_u (.clk_i(clk_i), .en_i(rx_en), .nine_i(nine),
      .period_i(period), .line_i(line), .valid_o(rx_v), .char_o(rx_c));

   // ****
   // Helpers
   // ****
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      if (w) wr_i <= 1'b1;
      else rd_i <= 1'b1;
      if (!w) rd_q.push_back(d);
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask : acc

   // Pins packed as irq, async, oe, line
   task automatic pins(input logic [3:0] m, input logic [3:0] e);
      #1;
      check({12'h000, {irq, async, oe, line} & m}, {12'h000, e});
   endtask : pins

   task automatic send(input logic n9);
      seed = lfsr(seed);
      rx_q.push_back({1'b0, nine ? n9 : 1'b0, seed[7:0]});
      acc(1'b1, uart_tx_pkg::DATA_ADDR, {8'h00, seed[7:0]});
   endtask : send

   task automatic drain;
      int k;
      for (k = 0; k < 5000 && rx_q.size() > 0; k++) @(posedge clk_i);
      if (rx_q.size() > 0) begin
         error_cnt++;
         conclude();
      end
   endtask : drain

   // ****
   // Result watcher
   // ****
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      if (rd_d) check(rdata_o, rd_q.pop_front());
      if (rx_v && rx_q.size() == 0) check({6'h00, rx_c}, 16'hffff);
      else if (rx_v) check({6'h00, rx_c}, {6'h00, rx_q.pop_front()});
   end

   // ****
   // Main sequence
   // ****
   initial begin
      idle(6);
      rst_i <= 1'b0;
      pins(4'h3, 4'h1);
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0002);
      acc(1'b0, uart_tx_pkg::CTRL_ADDR, 16'h0000);
      acc(1'b1, uart_tx_pkg::DIV_ADDR, 16'h0103);
      acc(1'b0, uart_tx_pkg::DIV_ADDR, 16'h0103);
      acc(1'b1, uart_tx_pkg::CTRL_ADDR, 16'h0003);
      idle(3);
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0003);
      pins(4'hf, 4'h7);
      acc(1'b1, uart_tx_pkg::STATUS_ADDR, 16'h0000);
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0003);
      acc(1'b0, uart_tx_pkg::DATA_ADDR, 16'h0000);
      acc(1'b0, 4'h7, 16'h0000);
      rx_en <= 1'b1;
      send(1'b0);
      send(1'b0);
      idle(3);
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0000);
      drain();
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0003);
      nine <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         acc(1'b1, uart_tx_pkg::CTRL_ADDR, b[0] ? 16'h001b : 16'h000b);
         send(b[0]);
         drain();
      end
      nine <= 1'b0;
      period <= 16'h0104;
      acc(1'b1, uart_tx_pkg::CTRL_ADDR, 16'h0043);
      send(1'b0);
      drain();
      period <= 16'h0004;
      acc(1'b1, uart_tx_pkg::CTRL_ADDR, 16'h0023);
      idle(3);
      pins(4'hf, 4'hf);
      rx_en <= 1'b0;
      acc(1'b1, uart_tx_pkg::DATA_ADDR, 16'h0055);
      idle(12);
      acc(1'b1, uart_tx_pkg::CTRL_ADDR, 16'h0000);
      idle(2);
      pins(4'hf, 4'h5);
      acc(1'b0, uart_tx_pkg::STATUS_ADDR, 16'h0002);
      rx_en <= 1'b1;
      acc(1'b1, uart_tx_pkg::CTRL_ADDR, 16'h0007);
      acc(1'b1, uart_tx_pkg::DATA_ADDR, 16'h00a5);
      idle(60);
      pins(4'h5, 4'h1);
      conclude();
   end
endmodule : testbench
`default_nettype wire

// >>> verilog/baud_tick.sv
// Down-counting baud divider producing a one-cycle tick.
// Assumes the divisor is stable while enabled.
`timescale 1ns/1ps
`default_nettype none
module baud_tick #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Control
   input  wire logic         run_i,
   input  wire logic         wide_i,
   input  wire logic [W-1:0] div_i,
   // Tick out
   output logic              tick_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } st_s;

   st_s st_r;
   st_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (!run_i) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt == '0) begin
         st_nxt.tick = 1'b1;
         st_nxt.cnt  = wide_i ? div_i : {{(W-8){1'b0}}, div_i[7:0]};
      end else begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_o = st_r.tick;

endmodule : baud_tick
`default_nettype wire

// >>> verilog/uart_tx.sv
// Asynchronous serial transmitter with holding and shift registers.
// Assumes a register port master on clk_i and a 20 MHz clock.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_tx (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Register port
   input  wire logic [3:0]        addr_i,
   input  wire logic [15:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic [15:0]            rdata_o,
   // Serial pin
   output logic                   serial_out_o,
   output logic                   serial_out_oe_o,
   // Shared settings and events
   output logic                   transmit_irq_o,
   output logic                   async_mode_o
);
   // ***********************************
   // State
   // ***********************************
   typedef struct packed {
      logic [6:0]                 ctrl;
      logic [15:0]                div;
      logic [8:0]                 hold;
      logic                       hold_full;
      logic [8:0]                 shift;
      logic [3:0]                 bits_left;
      uart_tx_pkg::tx_state_e     state;
      logic [1:0]                 lag;
      logic                       ready;
      logic                       empty;
      logic                       line;
      logic                       oe;
      logic                       irq;
      logic [15:0]                rdata;
   } st_s;

   st_s  st_r;
   st_s  st_nxt;
   logic tick;
   logic enabled;
   logic wr_data;

   assign enabled = st_r.ctrl[uart_tx_pkg::CTRL_TX_EN]
                  & st_r.ctrl[uart_tx_pkg::CTRL_PORT_EN]
                  & ~st_r.ctrl[uart_tx_pkg::CTRL_SYNC];
   assign wr_data = wr_i && addr_i == uart_tx_pkg::DATA_ADDR;

   // ***********************************
   // Baud rate generator
   // ***********************************
   baud_tick #(
      .W      (16)
   ) u_baud (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (enabled),
      .wide_i (st_r.ctrl[uart_tx_pkg::CTRL_DIV16]),
      .div_i  (st_r.div),
      .tick_o (tick)
   );

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      st_nxt = st_r;
      // Register writes; status is read only
      // flag not writable
      if (wr_i) begin
         if (addr_i == uart_tx_pkg::CTRL_ADDR) begin
            st_nxt.ctrl = wdata_i[6:0];
         end else if (addr_i == uart_tx_pkg::DIV_ADDR) begin
            st_nxt.div = wdata_i;
         end
      end
      if (wr_data && enabled) begin
         st_nxt.hold      = {st_r.ctrl[uart_tx_pkg::CTRL_NINTH_D],
                             wdata_i[7:0]};
         st_nxt.hold_full = 1'b1;
         st_nxt.lag       = 2'(uart_tx_pkg::READY_LAG);
      end
      // Shifter state machine, one tick per bit
      case (st_r.state)
         uart_tx_pkg::ST_IDLE: begin
            st_nxt.line = 1'b1;
         end
         uart_tx_pkg::ST_START: begin
            if (tick) begin
               st_nxt.state = uart_tx_pkg::ST_DATA;
               st_nxt.line  = st_r.shift[0];
               st_nxt.shift = {1'b0, st_r.shift[8:1]};
            end
         end
         uart_tx_pkg::ST_DATA: begin
            if (tick) begin
               st_nxt.bits_left = st_r.bits_left - 4'h1;
               if (st_r.bits_left == 4'h1) begin
                  st_nxt.state = uart_tx_pkg::ST_STOP;
                  st_nxt.line  = 1'b1;
               end else begin
                  st_nxt.line  = st_r.shift[0];
                  st_nxt.shift = {1'b0, st_r.shift[8:1]};
               end
            end
         end
         uart_tx_pkg::ST_STOP: begin
            if (tick) begin
               st_nxt.state = uart_tx_pkg::ST_IDLE;
               st_nxt.line  = 1'b1;
               st_nxt.empty = 1'b1;
            end
         end
         default: st_nxt.state = uart_tx_pkg::ST_IDLE;
      endcase
      // transfer when idle or on the tick ending the stop bit, start bit at once
      if (st_r.hold_full && enabled &&
          (st_r.state == uart_tx_pkg::ST_IDLE ||
           (st_r.state == uart_tx_pkg::ST_STOP && tick))) begin
         st_nxt.shift     = st_r.hold;
         st_nxt.hold_full = wr_data;
         // eight or nine bits with no parity logic
         st_nxt.bits_left = st_r.ctrl[uart_tx_pkg::CTRL_NINE] ? 4'h9 : 4'h8;
         st_nxt.state     = uart_tx_pkg::ST_START;
         st_nxt.line      = 1'b0;
         st_nxt.empty     = 1'b0;
      end
      if (!enabled) begin
         st_nxt.state     = uart_tx_pkg::ST_IDLE;
         st_nxt.hold_full = 1'b0;
         st_nxt.line      = 1'b1;
         st_nxt.empty     = 1'b1;
      end
      if (st_r.lag != 2'h0) begin
         st_nxt.lag = st_r.lag - 2'h1;
      end
      if (!(wr_data && enabled) && (st_r.lag <= 2'h1)) begin
         st_nxt.ready = enabled & ~st_nxt.hold_full;
      end
      st_nxt.irq = st_r.ready & st_r.ctrl[uart_tx_pkg::CTRL_IRQ_EN];
      // pin driven only while port enabled
      st_nxt.oe  = st_r.ctrl[uart_tx_pkg::CTRL_PORT_EN]
                 & st_r.ctrl[uart_tx_pkg::CTRL_TX_EN];
      // Read data, one cycle later
      st_nxt.rdata = 16'h0000;
      if (rd_i) begin
         if (addr_i == uart_tx_pkg::CTRL_ADDR) begin
            st_nxt.rdata = {9'h000, st_r.ctrl};
         end else if (addr_i == uart_tx_pkg::STATUS_ADDR) begin
            st_nxt.rdata = {14'h0000, st_r.empty, st_r.ready};
         end else if (addr_i == uart_tx_pkg::DIV_ADDR) begin
            st_nxt.rdata = st_r.div;
         end else begin
            st_nxt.rdata = 16'h0000;
         end
      end
   end

   // ***********************************
   // State register
   // ***********************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r       <= '0;
         st_r.ctrl  <= uart_tx_pkg::CTRL_RESET;
         st_r.div   <= uart_tx_pkg::DIV_RESET;
         st_r.state <= uart_tx_pkg::ST_IDLE;
         st_r.empty <= 1'b1;
         st_r.line  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign rdata_o         = st_r.rdata;
   assign serial_out_o    = st_r.line;
   assign serial_out_oe_o = st_r.oe;
   assign transmit_irq_o  = st_r.irq;
   // shared format setting for the receiver
   assign async_mode_o    = ~st_r.ctrl[uart_tx_pkg::CTRL_SYNC];

   // ***********************************
   // Checks
   // ***********************************
   sequence s_load;
      st_r.state == uart_tx_pkg::ST_START && $past(st_r.state) !=
         uart_tx_pkg::ST_START;
   endsequence

   chk_idle_mark: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == uart_tx_pkg::ST_IDLE |-> serial_out_o)
      else $error("line not at mark while idle");
   chk_start_space: assert property (@(posedge clk_i) disable iff (rst_i)
      s_load |-> !serial_out_o)
      else $error("start bit not at space");
   chk_bit_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r.state != uart_tx_pkg::ST_IDLE && !tick && enabled)
      |=> $stable(serial_out_o))
      else $error("line changed without baud tick");
   chk_stop_mark: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == uart_tx_pkg::ST_STOP |-> serial_out_o)
      else $error("stop bit not at mark");
   chk_empty_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.state != uart_tx_pkg::ST_IDLE |-> !st_r.empty)
      else $error("empty status set while shifting");
   chk_ready_lag: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_data && enabled) |=> $stable(st_r.ready))
      else $error("ready flag moved right after write");
   chk_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !enabled |=> st_r.state == uart_tx_pkg::ST_IDLE && !st_r.hold_full)
      else $error("disable did not abort");
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      transmit_irq_o |-> $past(st_r.ctrl[uart_tx_pkg::CTRL_IRQ_EN]))
      else $error("interrupt without enable");
   chk_ready_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      (enabled && !st_r.hold_full && st_r.lag == 2'h0 && !wr_data)
      ##1 (enabled && !wr_data) |=> st_r.ready)
      else $error("ready flag not set when empty");

endmodule : uart_tx
`default_nettype wire
